// ===== cpu_xfer_pkg.sv
package cpu_xfer_pkg;

	typedef enum logic [3:0] {
		CL_XFER, CL_ARITH, CL_LOGIC, CL_SHIFT, CL_BIT, CL_BRANCH, CL_SYS, CL_BLOCK, CL_NONE
	} class_t;

	typedef enum logic {S_IDLE, S_MEM} state_t;

	// Operand sizes
	localparam logic [1:0] SZ_B = 2'h0;
	localparam logic [1:0] SZ_W = 2'h1;
	localparam logic [1:0] SZ_L = 2'h2;
	localparam logic [2:0] BYTES_B = 3'h1;
	localparam logic [2:0] BYTES_W = 3'h2;
	localparam logic [2:0] BYTES_L = 3'h4;

	// Operand source / access kind
	localparam logic [2:0] MD_REG = 3'h0;
	localparam logic [2:0] MD_IMM = 3'h1;
	localparam logic [2:0] MD_LOAD = 3'h2;
	localparam logic [2:0] MD_STORE = 3'h3;
	localparam logic [2:0] MD_FETCH = 3'h4;

	// Pointer update
	localparam logic [1:0] AM_PLAIN = 2'h0;
	localparam logic [1:0] AM_POSTINC = 2'h1;
	localparam logic [1:0] AM_PREDEC = 2'h2;

	// Instruction numbering, grouped by class
	localparam logic [6:0] ID_MOV = 7'h00;
	localparam logic [6:0] ID_PUSHPOP = 7'h01;
	localparam logic [6:0] ID_MULTI = 7'h02;
	localparam logic [6:0] ID_PSYNC_LD = 7'h03;
	localparam logic [6:0] ID_PSYNC_ST = 7'h04;
	localparam logic [6:0] ID_ARITH = 7'h05;
	localparam logic [6:0] ID_ADD_WITH_CARRY = 7'h09;
	localparam logic [6:0] ID_SUB_WITH_BORROW = 7'h0a;
	localparam logic [6:0] ID_DAA = 7'h0b;
	localparam logic [6:0] ID_DAS = 7'h0c;
	localparam logic [6:0] ID_MULDIV = 7'h11;
	localparam logic [6:0] ID_EXT = 7'h15;
	localparam logic [6:0] ID_LDMAC = 7'h19;
	localparam logic [6:0] ID_STMAC = 7'h1a;
	localparam logic [6:0] ID_CLRMAC = 7'h1b;
	localparam logic [6:0] ID_LOGIC = 7'h1c;
	localparam logic [6:0] ID_SHIFT = 7'h20;
	localparam logic [6:0] ID_BIT = 7'h28;
	localparam logic [6:0] ID_BRANCH = 7'h36;
	localparam logic [6:0] ID_SYS = 7'h3b;
	localparam logic [6:0] ID_BLOCK = 7'h44;
	localparam logic [6:0] ID_COUNT = 7'h45;

	// Bit operation kinds
	localparam logic [3:0] BT_SET = 4'h0;
	localparam logic [3:0] BT_CLR = 4'h1;
	localparam logic [3:0] BT_NOT = 4'h2;
	localparam logic [3:0] BT_TST = 4'h3;
	localparam logic [3:0] BT_LD = 4'h4;
	localparam logic [3:0] BT_ILD = 4'h5;
	localparam logic [3:0] BT_ST = 4'h6;
	localparam logic [3:0] BT_IST = 4'h7;
	localparam logic [3:0] BT_AND = 4'h8;
	localparam logic [3:0] BT_IAND = 4'h9;
	localparam logic [3:0] BT_OR = 4'ha;
	localparam logic [3:0] BT_IOR = 4'hb;
	localparam logic [3:0] BT_XOR = 4'hc;

	// Shift kinds; bit 0 set means rightward
	localparam logic [2:0] SH_SHAR = 3'h1;
	localparam logic [2:0] SH_ROTL = 3'h4;
	localparam logic [2:0] SH_ROTR = 3'h5;
	localparam logic [2:0] SH_ROTXL = 3'h6;
	localparam logic [2:0] SH_ROTXR = 3'h7;

	// Packed decimal
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
	localparam logic [7:0] BCD_ADJ_LO = 8'h06;
	localparam logic [7:0] BCD_ADJ_HI = 8'h60;

	localparam logic [2:0] SP_IDX = 3'h7;
	localparam int MAC_HI_W = 10;
	localparam int MAC_EXT_W = 22;

endpackage

// ===== cpu_xfer_core.sv
// Operation
// - Operands are bits, packed decimal digits, bytes, words and longwords.
// - Bit operations select one bit, 0 to 7, of a byte.
// - Decimal adjust treats a byte as two packed decimal digits.
// - Odd word or longword data address: bit 0 forced low, no error.
// - Instruction fetch address gets the same bit 0 forcing.
// - Decoder knows 69 instructions in eight classes.
// - Shift class has eight kinds, each byte, word or longword.
// - Bit class has fourteen byte-sized kinds using the carry flag.
// - Carry add/subtract and decimal adjust byte only; multiply/divide byte or word.
// - Peripheral-synchronised byte transfers are unsupported.
// - Pop equals load from stack pointer with post-increment.
// - Push equals store with stack pointer pre-decrement.
// - Multi-register restore loads two or more longword registers from stack.
// - Multi-register save stores two or more longword registers on stack.
// - Register file seen as 16 bytes, 16 words, 8 longwords, shared.
// - Move goes register to register, register to or from memory, or immediate.
// - Accumulator is 64 bits; upper half keeps 10 bits, sign-extended.
`timescale 1ns/1ns
`default_nettype none
module cpu_xfer_core import cpu_xfer_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Command
	input wire logic cmd_valid,
	input wire logic [6:0] cmd_inst,
	input wire logic [1:0] cmd_size,
	input wire logic [2:0] cmd_mode,
	input wire logic [1:0] cmd_am,
	input wire logic [3:0] cmd_rd,
	input wire logic [3:0] cmd_rs,
	input wire logic [31:0] cmd_imm,
	output logic cmd_ready_q,
	// Status
	output logic done_q,
	output logic illegal_q,
	output class_t class_q,
	output logic [31:0] result_q,
	output logic [15:0] fetch_word_q,
	output logic c_q,
	output logic z_q,
	output logic h_q,
	// Memory bus
	output logic mem_req_q,
	output logic mem_we_q,
	output logic [31:0] mem_addr_q,
	output logic [7:0] mem_wdata_q,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata
);

////////////////////////////////////////////////////////////////////////////////

function automatic class_t class_of(input logic [6:0] id);
	if (id < ID_ARITH) return CL_XFER;
	else if (id < ID_LOGIC) return CL_ARITH;
	else if (id < ID_SHIFT) return CL_LOGIC;
	else if (id < ID_BIT) return CL_SHIFT;
	else if (id < ID_BRANCH) return CL_BIT;
	else if (id < ID_SYS) return CL_BRANCH;
	else if (id < ID_BLOCK) return CL_SYS;
	else if (id < ID_COUNT) return CL_BLOCK;
	return CL_NONE;
endfunction

function automatic logic size_ok(input logic [6:0] id, input logic [1:0] sz);
	if (sz != SZ_B && sz != SZ_W && sz != SZ_L) return 1'b0;
	if (id == ID_PSYNC_LD || id == ID_PSYNC_ST) return 1'b0;
	if (id >= ID_ADD_WITH_CARRY && id <= ID_DAS) return sz == SZ_B;
	if (id >= ID_MULDIV && id < ID_EXT) return sz != SZ_L;
	if (id == ID_PUSHPOP) return sz != SZ_B;
	if (id == ID_MULTI) return sz == SZ_L;
	if (class_of(id) == CL_BIT) return sz == SZ_B;
	return id < ID_COUNT;
endfunction

function automatic logic [2:0] nbytes(input logic [1:0] sz);
	return (sz == SZ_B) ? BYTES_B : ((sz == SZ_W) ? BYTES_W : BYTES_L);
endfunction

function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] sz);
	return (sz == SZ_B) ? a : {a[31:1], 1'b0};
endfunction

function automatic logic [31:0] ljust(input logic [31:0] v, input logic [1:0] sz);
	if (sz == SZ_B) return {v[7:0], 24'h0};
	if (sz == SZ_W) return {v[15:0], 16'h0};
	return v;
endfunction

function automatic logic [31:0] reg_get(input logic [31:0] w, input logic [3:0] idx,
		input logic [1:0] sz);
	if (sz == SZ_B) return idx[3] ? {24'h0, w[7:0]} : {24'h0, w[15:8]};
	if (sz == SZ_W) return idx[3] ? {16'h0, w[31:16]} : {16'h0, w[15:0]};
	return w;
endfunction

function automatic logic [31:0] reg_put(input logic [31:0] w, input logic [3:0] idx,
		input logic [1:0] sz, input logic [31:0] v);
	logic [31:0] r;
	r = w;
	if (sz == SZ_B) begin
		if (idx[3]) r[7:0] = v[7:0];
		else r[15:8] = v[7:0];
	end else if (sz == SZ_W) begin
		if (idx[3]) r[31:16] = v[15:0];
		else r[15:0] = v[15:0];
	end else begin
		r = v;
	end
	return r;
endfunction

// Returns {carry, result}
function automatic logic [32:0] shift_op(input logic [31:0] v, input logic [1:0] sz,
		input logic [2:0] k, input logic c);
	logic [31:0] m;
	logic [31:0] t;
	logic [31:0] r;
	logic top;
	logic fill;
	m = (sz == SZ_B) ? 32'hff : ((sz == SZ_W) ? 32'hffff : 32'hffffffff);
	t = m & ~(m >> 1);
	top = |(v & t);
	if (!k[0]) begin
		fill = (k == SH_ROTL) ? top : ((k == SH_ROTXL) ? c : 1'b0);
		r = ((v & m) << 1) | {31'h0, fill};
		return {top, r & m};
	end
	case (k)
		SH_SHAR: fill = top;
		SH_ROTR: fill = v[0];
		SH_ROTXR: fill = c;
		default: fill = 1'b0;
	endcase
	r = ((v & m) >> 1) | (fill ? t : 32'h0);
	return {v[0], r};
endfunction

// Returns {carry, zero, byte}
function automatic logic [9:0] bit_op(input logic [7:0] v, input logic [2:0] n,
		input logic [3:0] k, input logic c);
	logic [7:0] r;
	logic b;
	logic co;
	r = v;
	b = v[n];
	co = c;
	case (k)
		BT_SET: r[n] = 1'b1;
		BT_CLR: r[n] = 1'b0;
		BT_NOT: r[n] = ~b;
		BT_TST: co = c;
		BT_LD: co = b;
		BT_ILD: co = ~b;
		BT_ST: r[n] = c;
		BT_IST: r[n] = ~c;
		BT_AND: co = c & b;
		BT_IAND: co = c & ~b;
		BT_OR: co = c | b;
		BT_IOR: co = c | ~b;
		BT_XOR: co = c ^ b;
		default: co = c ^ ~b;
	endcase
	return {co, ~b, r};
endfunction

// Returns {carry, byte}
function automatic logic [8:0] dec_adj(input logic [7:0] v, input logic c, input logic h,
		input logic sub);
	logic [7:0] adj;
	logic co;
	adj = 8'h0;
	co = c;
	if (h || (!sub && v[3:0] > BCD_DIGIT_MAX)) adj = adj | BCD_ADJ_LO;
	if (c || (!sub && v > BCD_BYTE_MAX)) begin
		adj = adj | BCD_ADJ_HI;
		co = 1'b1;
	end
	return {co, sub ? v - adj : v + adj};
endfunction

////////////////////////////////////////////////////////////////////////////////

state_t state_q;
logic [31:0] regs_q [8];
logic [31:0] data_q;
logic [2:0] bcnt_q, left_q, cur_q;
logic [3:0] rd_q;
logic [1:0] sz_q;
logic multi_q, fetch_q;
logic [MAC_HI_W-1:0] mac_hi_q;
logic [31:0] mac_lo_q;

logic acc, ok, is_fetch, is_mem, is_st, is_multi, sub, last_ack;
logic [2:0] ptr, cnt, bsel;
logic [1:0] am, esz;
logic [3:0] bk;
logic [7:0] abyte;
logic [31:0] a, b, pv, step, base, stl, nxt;

always_comb begin
	acc = cmd_valid && cmd_ready_q;
	is_fetch = cmd_mode == MD_FETCH;
	is_st = cmd_mode == MD_STORE;
	is_multi = cmd_inst == ID_MULTI && !is_fetch;
	ok = size_ok(cmd_inst, cmd_size) && !(is_multi && cmd_imm[1:0] == 2'h0);
	is_mem = is_fetch || (ok && (cmd_mode == MD_LOAD || is_st) && cmd_inst <= ID_MULTI);
	a = reg_get(regs_q[cmd_rd[2:0]], cmd_rd, cmd_size);
	b = (cmd_mode == MD_IMM) ? cmd_imm : reg_get(regs_q[cmd_rs[2:0]], cmd_rs, cmd_size);
	abyte = a[7:0];
	bsel = cmd_imm[2:0];
	cnt = {1'b0, cmd_imm[1:0]} + 3'h1;
	ptr = (cmd_inst == ID_MOV) ? cmd_rs[2:0] : SP_IDX;
	esz = is_multi ? SZ_L : (is_fetch ? SZ_W : cmd_size);
	am = cmd_am;
	if (cmd_inst != ID_MOV) am = is_st ? AM_PREDEC : AM_POSTINC;
	if (is_fetch) am = AM_PLAIN;
	step = is_multi ? 32'({cnt, 2'h0}) : 32'(nbytes(esz));
	pv = is_fetch ? cmd_imm : regs_q[ptr];
	base = (am == AM_PREDEC) ? pv - step : pv;
	stl = ljust(is_multi ? regs_q[3'(cmd_rd[2:0] + cnt - 3'h1)] : a, esz);
	nxt = regs_q[3'(cur_q - 3'h1)];
	last_ack = mem_req_q && mem_ack && bcnt_q == BYTES_B;
end

logic [8:0] sum, da;
logic [4:0] hs;
logic [32:0] shr;
logic [9:0] bo;
logic we, c_we, c_d, h_we, h_d, z_we, z_d;
logic [3:0] widx;
logic [1:0] wsz;
logic [31:0] wval;

always_comb begin
	sub = cmd_inst == ID_SUB_WITH_BORROW;
	sum = sub ? {1'b0, abyte} - {1'b0, b[7:0]} - {8'h0, c_q}
		: {1'b0, abyte} + {1'b0, b[7:0]} + {8'h0, c_q};
	hs = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c_q}
		: {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c_q};
	bk = 4'(cmd_inst - ID_BIT);
	shr = shift_op(a, cmd_size, 3'(cmd_inst - ID_SHIFT), c_q);
	bo = bit_op(abyte, bsel, bk, c_q);
	da = dec_adj(abyte, c_q, h_q, cmd_inst == ID_DAS);
	we = 1'b0;
	widx = cmd_rd;
	wsz = cmd_size;
	wval = b;
	c_we = 1'b0;
	c_d = c_q;
	h_we = 1'b0;
	h_d = hs[4];
	z_we = 1'b0;
	z_d = bo[8];
	if (state_q == S_MEM) begin
		if (last_ack && !mem_we_q && !fetch_q) begin
			we = 1'b1;
			widx = multi_q ? {1'b0, cur_q} : rd_q;
			wsz = sz_q;
			wval = {data_q[23:0], mem_rdata};
		end
	end else if (acc && is_mem) begin
		we = am != AM_PLAIN;
		widx = {1'b0, ptr};
		wsz = SZ_L;
		wval = (am == AM_POSTINC) ? pv + step : base;
	end else if (acc && ok) begin
		we = 1'b1;
		if (cmd_inst == ID_MOV) begin
			wval = b;
		end else if (cmd_inst == ID_ADD_WITH_CARRY || sub) begin
			wval = {24'h0, sum[7:0]};
			c_we = 1'b1;
			c_d = sum[8];
			h_we = 1'b1;
		end else if (cmd_inst == ID_DAA || cmd_inst == ID_DAS) begin
			wval = {24'h0, da[7:0]};
			c_we = 1'b1;
			c_d = da[8];
		end else if (class_of(cmd_inst) == CL_SHIFT) begin
			wval = shr[31:0];
			c_we = 1'b1;
			c_d = shr[32];
		end else if (class_of(cmd_inst) == CL_BIT) begin
			wval = {24'h0, bo[7:0]};
			c_we = 1'b1;
			c_d = bo[9];
			z_we = bk == BT_TST;
		end else if (cmd_inst == ID_STMAC) begin
			wsz = SZ_L;
			wval = cmd_rs[0] ? {{MAC_EXT_W{mac_hi_q[MAC_HI_W-1]}}, mac_hi_q} : mac_lo_q;
		end else begin
			we = 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge core_clk) begin
	if (rst) begin
		state_q <= S_IDLE;
		cmd_ready_q <= 1'b1;
		done_q <= 1'b0;
	end else begin
		done_q <= 1'b0;
		if (state_q == S_IDLE) begin
			if (acc) begin
				done_q <= !is_mem;
				if (is_mem) begin
					state_q <= S_MEM;
					cmd_ready_q <= 1'b0;
				end
			end
		end else if (last_ack && left_q == 3'h0) begin
			state_q <= S_IDLE;
			cmd_ready_q <= 1'b1;
			done_q <= 1'b1;
		end
	end
end

always_ff @(posedge core_clk) begin
	if (rst) begin
		mem_req_q <= 1'b0;
		mem_we_q <= 1'b0;
		mem_addr_q <= 32'h0;
		mem_wdata_q <= 8'h0;
		data_q <= 32'h0;
		bcnt_q <= 3'h0;
		left_q <= 3'h0;
		cur_q <= 3'h0;
		rd_q <= 4'h0;
		sz_q <= SZ_B;
		multi_q <= 1'b0;
		fetch_q <= 1'b0;
	end else if (state_q == S_IDLE) begin
		if (acc && is_mem) begin
			mem_req_q <= 1'b1;
			mem_we_q <= is_st;
			mem_addr_q <= align(base, esz);
			data_q <= stl;
			mem_wdata_q <= stl[31:24];
			bcnt_q <= nbytes(esz);
			left_q <= is_multi ? cnt - 3'h1 : 3'h0;
			cur_q <= 3'(cmd_rd[2:0] + cnt - 3'h1);
			rd_q <= cmd_rd;
			sz_q <= esz;
			multi_q <= is_multi;
			fetch_q <= is_fetch;
		end
	end else if (mem_req_q && mem_ack) begin
		mem_addr_q <= mem_addr_q + 32'h1;
		if (bcnt_q != BYTES_B) begin
			bcnt_q <= bcnt_q - 3'h1;
			data_q <= {data_q[23:0], mem_rdata};
			mem_wdata_q <= data_q[23:16];
		end else if (left_q != 3'h0) begin
			left_q <= left_q - 3'h1;
			cur_q <= cur_q - 3'h1;
			bcnt_q <= BYTES_L;
			data_q <= nxt;
			mem_wdata_q <= nxt[31:24];
		end else begin
			mem_req_q <= 1'b0;
		end
	end
end

always_ff @(posedge core_clk) begin
	if (rst) begin
		for (int i = 0; i < 8; i++) regs_q[i] <= 32'h0;
	end else if (we) begin
		regs_q[widx[2:0]] <= reg_put(regs_q[widx[2:0]], widx, wsz, wval);
	end
end

always_ff @(posedge core_clk) begin
	if (rst) begin
		c_q <= 1'b0;
		h_q <= 1'b0;
		z_q <= 1'b0;
	end else begin
		if (c_we) c_q <= c_d;
		if (h_we) h_q <= h_d;
		if (z_we) z_q <= z_d;
	end
end

always_ff @(posedge core_clk) begin
	if (rst) begin
		mac_hi_q <= '0;
		mac_lo_q <= 32'h0;
	end else if (acc && ok && !is_mem) begin
		if (cmd_inst == ID_CLRMAC) begin
			mac_hi_q <= '0;
			mac_lo_q <= 32'h0;
		end else if (cmd_inst == ID_LDMAC && cmd_rd[0]) begin
			mac_hi_q <= b[MAC_HI_W-1:0];
		end else if (cmd_inst == ID_LDMAC) begin
			mac_lo_q <= b;
		end
	end
end

always_ff @(posedge core_clk) begin
	if (rst) begin
		illegal_q <= 1'b0;
		class_q <= CL_NONE;
		result_q <= 32'h0;
		fetch_word_q <= 16'h0;
	end else begin
		if (acc) begin
			illegal_q <= !is_fetch && !ok;
			class_q <= is_fetch ? class_q : class_of(cmd_inst);
		end
		if (we) result_q <= wval;
		if (last_ack && fetch_q) fetch_word_q <= {data_q[7:0], mem_rdata};
	end
end

////////////////////////////////////////////////////////////////////////////////

default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);

AST_ALIGN: assert property (mem_req_q && sz_q != SZ_B && bcnt_q == nbytes(sz_q)
	|-> !mem_addr_q[0]) else $error("word access starts at odd address");
AST_FETCH_ALIGN: assert property (acc && is_fetch
	|=> mem_req_q && !mem_we_q && mem_addr_q == ($past(cmd_imm) & ~32'h1))
	else $error("fetch address not forced even");
AST_PUSH: assert property (acc && ok && cmd_inst == ID_PUSHPOP && is_st && cmd_size == SZ_L
	|=> mem_we_q && regs_q[SP_IDX] == $past(regs_q[SP_IDX]) - 32'h4)
	else $error("push did not pre-decrement stack pointer");
AST_POP: assert property (acc && ok && cmd_inst == ID_PUSHPOP && cmd_mode == MD_LOAD
	&& cmd_size == SZ_W
	|=> !mem_we_q && mem_addr_q == ($past(regs_q[SP_IDX]) & ~32'h1)
	##0 regs_q[SP_IDX] == $past(regs_q[SP_IDX]) + 32'h2)
	else $error("pop did not read at stack pointer then increment");
AST_MULTI_SAVE: assert property (acc && ok && is_multi && is_st
	|=> mem_we_q && sz_q == SZ_L && left_q == $past(cnt) - 3'h1 && left_q != 3'h0)
	else $error("multi save not longword or too few registers");
AST_MULTI_RESTORE: assert property (acc && is_mem && is_multi && !is_st
	|=> !mem_we_q && sz_q == SZ_L && left_q != 3'h0)
	else $error("multi restore not longword or too few registers");
AST_MSB_FIRST: assert property (acc && is_mem && is_st && !is_multi && cmd_size == SZ_W
	|=> {16'h0, mem_wdata_q, 8'h0} == ($past(a) & 32'hff00))
	else $error("first stored byte is not the high byte");
AST_PSYNC: assert property (acc && !is_fetch
	&& (cmd_inst == ID_PSYNC_LD || cmd_inst == ID_PSYNC_ST)
	|=> illegal_q && done_q && !mem_req_q) else $error("peripheral sync transfer accepted");
AST_BYTE_ONLY: assert property (acc && !is_fetch && cmd_size != SZ_B
	&& (cmd_inst == ID_DAA || cmd_inst == ID_ADD_WITH_CARRY)
	|=> illegal_q && result_q == $past(result_q)) else $error("byte-only operation ran wide");
AST_SHIFT_CLASS: assert property (acc && !is_fetch && cmd_inst >= ID_SHIFT
	&& cmd_inst < ID_BIT |=> class_q == CL_SHIFT) else $error("shift misclassified");
AST_BIT_SET: assert property (acc && ok && !is_mem && cmd_inst == ID_BIT
	|=> result_q[7:0] == ($past(abyte) | (8'h1 << $past(bsel))))
	else $error("bit set hit wrong bit");
AST_DAA: assert property (acc && ok && !is_mem && cmd_inst == ID_DAA
	&& !c_q && !h_q && abyte == 8'h0a |=> result_q[7:0] == 8'h10 && !c_q)
	else $error("decimal adjust wrong");

COV_MULTI_SAVE: cover property (acc && ok && is_multi && is_st);
COV_FETCH: cover property (last_ack && fetch_q);
COV_DAA: cover property (acc && ok && cmd_inst == ID_DAA);

endmodule
`default_nettype wire

// ===== cpu_bus_mem.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_mem (
	// Clock
	input wire logic core_clk,
	// Pace
	input wire logic slow,
	// Memory bus
	input wire logic mem_req_q,
	input wire logic mem_we_q,
	input wire logic [31:0] mem_addr_q,
	input wire logic [7:0] mem_wdata_q,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:4095];
	logic phase_q = 1'b0;
	logic [7:0] last_q = 8'h00;
	int n_wr = 0;

	// Slow pace acknowledges every other cycle
	assign mem_ack = mem_req_q && (!slow || phase_q);
	// Released data line shows the inverse of the last byte
	assign mem_rdata = (mem_ack && !mem_we_q) ? mem[mem_addr_q[11:0]] : ~last_q;

	always @(posedge core_clk) begin
		phase_q <= mem_req_q ? !phase_q : 1'b0;
		if (mem_ack && mem_we_q) begin
			mem[mem_addr_q[11:0]] <= mem_wdata_q;
			n_wr <= n_wr + 1;
		end
		if (mem_ack && !mem_we_q) begin
			last_q <= mem[mem_addr_q[11:0]];
		end
	end
endmodule
`default_nettype wire

// ===== cpu_data_format_and_transfer_test.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_data_format_and_transfer_test import cpu_xfer_pkg::*;;
	logic core_clk;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic [6:0] cmd_inst = 7'h00;
	logic [1:0] cmd_size = 2'h0;
	logic [2:0] cmd_mode = 3'h0;
	logic [1:0] cmd_am = 2'h0;
	logic [1:0] am_sel = 2'h0;
	logic [3:0] cmd_rd = 4'h0;
	logic [3:0] cmd_rs = 4'h0;
	logic [31:0] cmd_imm = 32'h0;
	logic cmd_ready_q, done_q, illegal_q, c_q, z_q, h_q;
	class_t class_q;
	logic [31:0] result_q, mem_addr_q;
	logic [15:0] fetch_word_q;
	logic mem_req_q, mem_we_q, mem_ack, slow;
	logic [7:0] mem_wdata_q, mem_rdata;
	int errors = 0;
	int n_checks = 0;

	cpu_xfer_core uut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_inst(cmd_inst), .cmd_size(cmd_size), .cmd_mode(cmd_mode), .cmd_am(cmd_am),
		.cmd_rd(cmd_rd), .cmd_rs(cmd_rs), .cmd_imm(cmd_imm), .cmd_ready_q(cmd_ready_q),
		.done_q(done_q), .illegal_q(illegal_q), .class_q(class_q), .result_q(result_q),
		.fetch_word_q(fetch_word_q), .c_q(c_q), .z_q(z_q), .h_q(h_q),
		.mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
		.mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	cpu_bus_mem mem_m (.core_clk(core_clk), .slow(slow), .mem_req_q(mem_req_q),
		.mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmd(input logic [6:0] inst, input logic [1:0] sz, input logic [2:0] md,
			input logic [3:0] rd, input logic [3:0] rs, input logic [31:0] imm);
		int n;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_inst <= inst;
		cmd_size <= sz;
		cmd_mode <= md;
		cmd_am <= am_sel;
		cmd_rd <= rd;
		cmd_rs <= rs;
		cmd_imm <= imm;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (cmd_ready_q !== 1'b1 && n < 50);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (done_q !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			$display("CHECK FAILED at %0t: command never completed", $time);
		end
	endtask

	task automatic setreg(input logic [3:0] r, input logic [31:0] v);
		cmd(ID_MOV, SZ_L, MD_IMM, r, 4'h0, v);
	endtask

	task automatic readreg(input logic [3:0] r, input logic [31:0] exp);
		cmd(ID_MOV, SZ_L, MD_REG, r, r, 32'h0);
		chk(result_q, exp);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_bcd();
		setreg(4'h3, 32'h05);
		setreg(4'h4, 32'h05);
		cmd(ID_ADD_WITH_CARRY, SZ_B, MD_REG, 4'hb, 4'hc, 32'h0);
		chk({24'h0, result_q[7:0]}, 32'h0a);
		chk({31'h0, c_q}, 32'h0);
		cmd(ID_DAA, SZ_B, MD_REG, 4'hb, 4'hb, 32'h0);
		chk({24'h0, result_q[7:0]}, 32'h10);
		cmd(ID_SUB_WITH_BORROW, SZ_B, MD_IMM, 4'hb, 4'h0, 32'h05);
		chk({30'h0, h_q, c_q}, 32'h2);
		cmd(ID_DAS, SZ_B, MD_REG, 4'hb, 4'hb, 32'h0);
		chk({24'h0, result_q[7:0]}, 32'h05);
	endtask

	task automatic test_stack();
		slow <= 1'b1;
		setreg(4'h7, 32'h100);
		setreg(4'h0, 32'h11223344);
		cmd(ID_PUSHPOP, SZ_L, MD_STORE, 4'h0, 4'h0, 32'h0);
		chk({mem_m.mem[12'hfc], mem_m.mem[12'hfd], mem_m.mem[12'hfe], mem_m.mem[12'hff]},
			32'h11223344);
		cmd(ID_PUSHPOP, SZ_W, MD_STORE, 4'h0, 4'h0, 32'h0);
		chk({16'h0, mem_m.mem[12'hfa], mem_m.mem[12'hfb]}, 32'h3344);
		cmd(ID_PUSHPOP, SZ_W, MD_LOAD, 4'h1, 4'h0, 32'h0);
		chk({16'h0, result_q[15:0]}, 32'h3344);
		cmd(ID_PUSHPOP, SZ_L, MD_LOAD, 4'h2, 4'h0, 32'h0);
		chk(result_q, 32'h11223344);
		am_sel = AM_PREDEC;
		cmd(ID_MOV, SZ_W, MD_STORE, 4'h8, 4'h7, 32'h0);
		chk({16'h0, mem_m.mem[12'hfe], mem_m.mem[12'hff]}, 32'h1122);
		am_sel = AM_POSTINC;
		cmd(ID_MOV, SZ_W, MD_LOAD, 4'h9, 4'h7, 32'h0);
		chk({16'h0, result_q[15:0]}, 32'h1122);
		am_sel = AM_PLAIN;
		readreg(4'h7, 32'h100);
		slow <= 1'b0;
	endtask

	task automatic test_odd();
		setreg(4'h2, 32'h201);
		cmd(ID_MOV, SZ_W, MD_STORE, 4'h0, 4'h2, 32'h0);
		chk({16'h0, mem_m.mem[12'h200], mem_m.mem[12'h201]}, 32'h3344);
		cmd(ID_MOV, SZ_L, MD_LOAD, 4'h5, 4'h2, 32'h0);
		chk(result_q, 32'h33445566);
		chk({31'h0, illegal_q}, 32'h0);
		cmd(ID_MOV, SZ_W, MD_FETCH, 4'h0, 4'h0, 32'h301);
		chk({16'h0, fetch_word_q}, 32'habcd);
	endtask

	task automatic test_bits();
		setreg(4'h0, 32'h11223344);
		cmd(ID_BIT + 7'(BT_SET), SZ_B, MD_REG, 4'h8, 4'h8, 32'h7);
		chk({24'h0, result_q[7:0]}, 32'hc4);
		cmd(ID_BIT + 7'(BT_TST), SZ_B, MD_REG, 4'h8, 4'h8, 32'h2);
		chk({31'h0, z_q}, 32'h0);
		cmd(ID_BIT + 7'(BT_TST), SZ_B, MD_REG, 4'h8, 4'h8, 32'h0);
		chk({31'h0, z_q}, 32'h1);
	endtask

	task automatic test_multi();
		int n0;
		setreg(4'h0, 32'h11223344);
		setreg(4'h1, 32'h55667788);
		setreg(4'h7, 32'h180);
		n0 = mem_m.n_wr;
		cmd(ID_MULTI, SZ_L, MD_STORE, 4'h0, 4'h0, 32'h1);
		chk(32'(mem_m.n_wr - n0), 32'h8);
		chk({mem_m.mem[12'h178], mem_m.mem[12'h179], mem_m.mem[12'h17a], mem_m.mem[12'h17b]},
			32'h55667788);
		readreg(4'h7, 32'h178);
		setreg(4'h0, 32'h0);
		setreg(4'h1, 32'h0);
		cmd(ID_MULTI, SZ_L, MD_LOAD, 4'h0, 4'h0, 32'h1);
		readreg(4'h7, 32'h180);
		readreg(4'h0, 32'h11223344);
		readreg(4'h1, 32'h55667788);
	endtask

	task automatic test_mac();
		cmd(ID_LDMAC, SZ_L, MD_IMM, 4'h1, 4'h0, 32'h600);
		cmd(ID_LDMAC, SZ_L, MD_IMM, 4'h0, 4'h0, 32'h12345678);
		cmd(ID_STMAC, SZ_L, MD_REG, 4'h6, 4'h1, 32'h0);
		chk(result_q, 32'hfffffe00);
		cmd(ID_STMAC, SZ_L, MD_REG, 4'h6, 4'h0, 32'h0);
		chk(result_q, 32'h12345678);
		cmd(ID_CLRMAC, SZ_L, MD_REG, 4'h0, 4'h0, 32'h0);
		cmd(ID_STMAC, SZ_L, MD_REG, 4'h6, 4'h1, 32'h0);
		chk(result_q, 32'h0);
	endtask

	task automatic test_illegal();
		logic [6:0] ids [7] = '{ID_ADD_WITH_CARRY, ID_DAS, ID_MULDIV, ID_PSYNC_LD, ID_PSYNC_ST,
			ID_COUNT, ID_MOV};
		logic [1:0] szs [7] = '{SZ_W, SZ_L, SZ_L, SZ_B, SZ_B, SZ_B, 2'h3};
		for (int i = 0; i < 7; i++) begin
			cmd(ids[i], szs[i], MD_REG, 4'h0, 4'h0, 32'h0);
			chk({31'h0, illegal_q}, 32'h1);
		end
		cmd(ID_MULTI, SZ_L, MD_STORE, 4'h0, 4'h0, 32'h0);
		chk({31'h0, illegal_q}, 32'h1);
		cmd(ID_MULDIV, SZ_W, MD_REG, 4'h1, 4'h2, 32'h0);
		chk({31'h0, illegal_q}, 32'h0);
	endtask

	task automatic test_classes();
		logic [6:0] ids [8] = '{ID_MOV, ID_ARITH, ID_LOGIC, ID_SHIFT + 7'h07,
			ID_BIT + 7'h0d, ID_BRANCH, ID_SYS + 7'h08, ID_BLOCK};
		class_t cls [8] = '{CL_XFER, CL_ARITH, CL_LOGIC, CL_SHIFT, CL_BIT, CL_BRANCH,
			CL_SYS, CL_BLOCK};
		logic [1:0] szs [8] = '{SZ_L, SZ_L, SZ_W, SZ_L, SZ_B, SZ_B, SZ_B, SZ_B};
		for (int i = 0; i < 8; i++) begin
			cmd(ids[i], szs[i], MD_REG, 4'h3, 4'h3, 32'h1);
			chk(32'(class_q), 32'(cls[i]));
			chk({31'h0, illegal_q}, 32'h0);
		end
		cmd(ID_EXT + 7'h2, SZ_B, MD_REG, 4'h4, 4'h4, 32'h0);
		chk(32'(class_q), 32'(CL_ARITH));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		give_verdict();
	end

	initial begin
		slow = 1'b0;
		mem_m.mem[12'h202] = 8'h55;
		mem_m.mem[12'h203] = 8'h66;
		mem_m.mem[12'h300] = 8'hab;
		mem_m.mem[12'h301] = 8'hcd;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		test_bcd();
		test_stack();
		test_odd();
		test_bits();
		test_multi();
		test_illegal();
		test_classes();
		test_mac();
		give_verdict();
	end
endmodule
`default_nettype wire
